//--- src/frc_pkg.sv
// Constants, register map and reset values of the reference conditioner
//----------------------------------------------------------------------
// Notes on behaviour
// R1 - Raise reference below general lower limit
// R2 - Master limit only for analog master reference
// R3 - Effective lower limit is larger of both
// R4 - Clamp inside band to band's lower edge
// R5 - One shared width sizes every jump band
// R6 - All jump frequencies zero disables jumping
// R7 - Cross bands by ramp, never settle inside
// R8 - Other party orders jumps non-increasing
// R9 - Hold off: ramp-hold value zeroed at stop
// R10 - Hold off: up/down reference zeroed at stop
// R11 - Hold off: bias dropped at stop, 5 s
// R12 - Hold on: keep hold value, clear on release
// R13 - Hold on: keep up/down reference across stop
// R14 - Panel source: fold bias into reference after 5 s
// R15 - Other source: save bias after 5 s
// R16 - Clear saved reference on release or idle up/down
// R17 - Step zero: bias ramps while command held
// R18 - Step nonzero: one step per command
// R19 - Ramp select picks active or fourth rate
// R20 - Mode 1 zeroes bias when inputs equal
// R21 - Saved bias reset on listed conditions
// R22 - Freeze bias while analog reference moves fast
//----------------------------------------------------------------------
package frc_pkg;
   // Register byte offsets
   localparam logic [7:0] A_CTRL  = 8'h00; // Control bits
   localparam logic [7:0] A_LIM   = 8'h04; // Lower limits, 0.1 %
   localparam logic [7:0] A_MAXF  = 8'h08; // Max output freq, 0.01 Hz
   localparam logic [7:0] A_J12   = 8'h0C; // First / second jump
   localparam logic [7:0] A_J3W   = 8'h10; // Third jump / band width
   localparam logic [7:0] A_BIAS  = 8'h14; // Bias step / fluctuation
   localparam logic [7:0] A_SBIAS = 8'h18; // Saved bias, signed
   localparam logic [7:0] A_STAT  = 8'h1C; // Output and live bias
   localparam logic [7:0] A_HOLD  = 8'h20; // Held and up/down refs
   // Control field positions
   localparam int C_HOLD  = 0; // Hold select
   localparam int C_BRAMP = 1; // Bias ramp select
   localparam int C_BMODE = 2; // Bias mode select
   localparam int C_UD2   = 3; // Bias inputs assigned
   localparam int C_SRC   = 4; // Source, two bits
   localparam int C_UPDN  = 6; // Up/down reference in use
   // Reference sources
   localparam logic [1:0] SRC_OP = 2'h0; // Operator panel
   localparam logic [1:0] SRC_A1 = 2'h1; // First analog input
   localparam logic [1:0] SRC_A2 = 2'h2; // Second analog input
   // Reset values
   localparam logic [6:0]  CTRL_RST  = 7'h00;
   localparam logic [31:0] LIM_RST   = 32'h0000_0000;
   localparam logic [15:0] MAXF_RST  = 16'h1770;
   localparam logic [31:0] J12_RST   = 32'h0000_0000;
   localparam logic [31:0] J3W_RST   = 32'h0064_0000;
   localparam logic [31:0] BIAS_RST  = 32'h000A_0000;
   localparam logic [17:0] SBIAS_RST = 18'h00000;
   // Scaling and timing
   localparam logic [9:0] PCT_DIV  = 10'h3E8; // 0.1 % per count
   localparam int unsigned CLK_HZ  = 100_000_000;
   localparam int unsigned T_HOLD_S = 5;  // Bias release delay, s
   localparam int unsigned T_TICK_MS = 1; // Ramp tick, ms
   localparam int unsigned HOLD_CYC = T_HOLD_S * CLK_HZ;
   localparam int unsigned TICK_CYC = CLK_HZ / 1000 * T_TICK_MS;
endpackage

//--- src/frc_top.sv
// Frequency reference conditioner with AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module frc_top #(
   parameter int unsigned HOLD_N = frc_pkg::HOLD_CYC, // 5 s in cycles
   parameter int unsigned TICK_N = frc_pkg::TICK_CYC  // Ramp tick
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [15:0] ref_in,
   input  wire logic        ref_is_preset,
   input  wire logic        run,
   input  wire logic        power_ok,
   input  wire logic        updn_up,
   input  wire logic        updn_dn,
   input  wire logic        hold_in,
   input  wire logic        bias_up,
   input  wire logic        bias_dn,
   input  wire logic [15:0] rate_act,
   input  wire logic [15:0] rate_fourth,
   output logic      [15:0] freq_ref_out,
   output logic      [17:0] bias_out,
   output logic             jump_clamp,
   output logic             lower_clamp
);
   import frc_pkg::*;

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      logic        a_we;   // Write data phase pending
      logic [7:0]  a_adr;  // Latched address
      logic [31:0] rdat;   // Read data
      logic [6:0]  ctrl;   // Control bits
      logic [31:0] lim;    // Lower limits
      logic [15:0] maxf;   // Max output frequency
      logic [31:0] j12;    // Jumps one and two
      logic [31:0] j3w;    // Jump three and width
      logic [31:0] bcfg;   // Bias step and fluctuation
      logic [17:0] sbias;  // Saved bias
      logic [15:0] held;   // Ramp-hold value
      logic        held_v; // Ramp-hold value valid
      logic [15:0] udref;  // Up/down reference
      logic [17:0] opadj;  // Folded panel bias
      logic [17:0] bias;   // Live bias
      logic [31:0] tmr;    // Release timer
      logic        tmr_on; // Release timer running
      logic [31:0] tick;   // Ramp tick divider
      logic        up2_q;  // Bias up, last cycle
      logic        dn2_q;  // Bias down, last cycle
      logic        run_q;  // Run, last cycle
      logic        frz;    // Bias frozen
      logic [15:0] refp;   // Reference at last tick
      logic [15:0] out;    // Conditioned reference
      logic        jact;   // Jump clamp active
      logic        lact;   // Lower clamp active
   } frc_st_s;

   frc_st_s r_r;   // Registered state
   frc_st_s s_nxt; // Next state

   logic [15:0] gl;    // General lower limit, Hz
   logic [15:0] ml;    // Master lower limit, Hz
   logic [15:0] effl;  // Effective lower limit
   logic [15:0] flim;  // Fluctuation limit, Hz
   logic        jdis;  // Jumps disabled
   logic [15:0] jf  [3]; // Jump centres
   logic [15:0] jlo [3]; // Band lower edges
   logic [16:0] jhi [3]; // Band upper edges
   logic        tk;    // Ramp tick
   logic        stop;  // Run removed or power lost

   // Scale a 0.1 % setting by max output frequency
   function automatic logic [15:0] pct(input logic [15:0] m, input logic [10:0] p);
      logic [26:0] q;
      q = ({11'h000, m} * {16'h0000, p}) / {17'h00000, PCT_DIV};
      return q[15:0];
   endfunction

   // Clamp a signed bias to plus or minus the max frequency
   function automatic logic [17:0] clipb(input logic signed [18:0] v, input logic [15:0] m);
      logic signed [18:0] lim;
      lim = $signed({3'h0, m});
      if (v > lim) return lim[17:0];
      if (v < -lim) return 18'(-lim);
      return v[17:0];
   endfunction

   // Register read mux, from the post-write state
   function automatic logic [31:0] rdval(input frc_st_s s, input logic [7:0] a);
      case (a)
         A_CTRL:  return {25'h0, s.ctrl};
         A_LIM:   return s.lim;
         A_MAXF:  return {16'h0, s.maxf};
         A_J12:   return s.j12;
         A_J3W:   return s.j3w;
         A_BIAS:  return s.bcfg;
         A_SBIAS: return {{14{s.sbias[17]}}, s.sbias};
         A_STAT:  return {s.bias[15:0], s.out};
         A_HOLD:  return {s.udref, s.held};
         default: return 32'h0000_0000; // Unmapped reads zero
      endcase
   endfunction

   //------------------------------------------------------------
   // Limit and band arithmetic from registered settings
   //------------------------------------------------------------
   always_comb begin
      gl   = pct(r_r.maxf, r_r.lim[10:0]);
      ml   = pct(r_r.maxf, r_r.lim[26:16]);
      flim = pct(r_r.maxf, r_r.bcfg[26:16]);
      // Master limit only for an analog master, not presets
      if (!ref_is_preset && (r_r.ctrl[C_SRC+:2] == SRC_A1 ||
          r_r.ctrl[C_SRC+:2] == SRC_A2)) begin // R2
         effl = (ml > gl) ? ml : gl; // R3
      end else begin
         effl = gl;
      end
      jf[0] = r_r.j12[15:0];
      jf[1] = r_r.j12[31:16];
      jf[2] = r_r.j3w[15:0];
      jdis  = (jf[0] | jf[1] | jf[2]) == 16'h0000; // R6
      // One width shared by all three bands
      for (int i = 0; i < 3; i++) begin
         jlo[i] = (jf[i] > {1'b0, r_r.j3w[31:17]}) ? jf[i] - {1'b0, r_r.j3w[31:17]} : 16'h0000; // R5
         jhi[i] = {1'b0, jf[i]} + {2'b00, r_r.j3w[31:17]};
      end
      tk   = r_r.tick == 32'(TICK_N - 1);
      stop = (r_r.run_q & ~run) | ~power_ok;
   end

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      logic [15:0]        base;
      logic [15:0]        rate;
      logic [15:0]        v;
      logic signed [19:0] tot;
      logic signed [18:0] nb;
      logic               eq2;
      logic               clr;
      logic [15:0]        d;
      base = 16'h0000;
      rate = 16'h0000;
      v    = 16'h0000;
      tot  = 20'sh00000;
      nb   = 19'sh00000;
      eq2  = 1'b0;
      clr  = 1'b0;
      d    = 16'h0000;
      s_nxt = r_r;
      // Bus write in data phase
      if (r_r.a_we) begin
         case (r_r.a_adr)
            A_CTRL:  s_nxt.ctrl  = hwdata[6:0];
            A_LIM:   s_nxt.lim   = hwdata;
            A_MAXF:  s_nxt.maxf  = hwdata[15:0];
            A_J12:   s_nxt.j12   = hwdata;
            A_J3W:   s_nxt.j3w   = hwdata;
            A_BIAS:  s_nxt.bcfg  = hwdata;
            A_SBIAS: s_nxt.sbias = hwdata[17:0];
            default: ; // Unmapped writes dropped
         endcase
      end
      // Bus address phase
      s_nxt.a_we = 1'b0;
      if (hsel && hready && htrans[1]) begin
         s_nxt.a_we  = hwrite;
         s_nxt.a_adr = haddr[7:0];
         if (!hwrite) begin
            s_nxt.rdat = rdval(s_nxt, haddr[7:0]);
         end
      end
      // Ramp tick divider
      s_nxt.tick = tk ? 32'h0000_0000 : r_r.tick + 32'h0000_0001;
      s_nxt.run_q = run;
      s_nxt.up2_q = bias_up;
      s_nxt.dn2_q = bias_dn;
      // Ramp-hold value
      if (hold_in && !r_r.held_v && run) begin
         s_nxt.held   = r_r.out;
         s_nxt.held_v = 1'b1;
      end
      if (!hold_in || (stop && !r_r.ctrl[C_HOLD])) begin // R9 R12 R16
         s_nxt.held   = 16'h0000;
         s_nxt.held_v = 1'b0;
      end
      // Up/down generated reference, kept across stop when held
      if (tk && run && updn_up && !updn_dn) begin // R13
         s_nxt.udref = (r_r.udref > r_r.maxf - rate_act) ? r_r.maxf : r_r.udref + rate_act;
      end else if (tk && run && updn_dn && !updn_up) begin
         s_nxt.udref = (r_r.udref > rate_act) ? r_r.udref - rate_act : 16'h0000;
      end
      if (((updn_up || updn_dn) && !run) ||
          (stop && !r_r.ctrl[C_HOLD])) begin // R10 R16
         s_nxt.udref = 16'h0000;
      end
      // Bias ramp rate
      rate = r_r.ctrl[C_BRAMP] ? rate_fourth : rate_act; // R19
      eq2  = bias_up == bias_dn;
      // Bias adjustment
      if (!r_r.frz && run) begin
         if (r_r.bcfg[15:0] == 16'h0000) begin
            if (tk && bias_up && !bias_dn) begin // R17
               nb = $signed({r_r.bias[17], r_r.bias}) + $signed({3'h0, rate});
               s_nxt.bias = clipb(nb, r_r.maxf);
            end else if (tk && bias_dn && !bias_up) begin
               nb = $signed({r_r.bias[17], r_r.bias}) - $signed({3'h0, rate});
               s_nxt.bias = clipb(nb, r_r.maxf);
            end
         end else if (bias_up && !r_r.up2_q && !bias_dn) begin // R18
            nb = $signed({r_r.bias[17], r_r.bias}) + $signed({3'h0, r_r.bcfg[15:0]});
            s_nxt.bias = clipb(nb, r_r.maxf);
         end else if (bias_dn && !r_r.dn2_q && !bias_up) begin
            nb = $signed({r_r.bias[17], r_r.bias}) - $signed({3'h0, r_r.bcfg[15:0]});
            s_nxt.bias = clipb(nb, r_r.maxf);
         end
      end
      // Restart picks up the saved bias
      if (run && !r_r.run_q) begin // R15
         s_nxt.bias = r_r.sbias;
      end
      // Release timer
      if (bias_up || bias_dn) begin
         s_nxt.tmr_on = 1'b0;
      end else if (r_r.up2_q || r_r.dn2_q) begin
         s_nxt.tmr_on = 1'b1;
         s_nxt.tmr    = 32'h0000_0000;
      end else if (r_r.tmr_on) begin
         s_nxt.tmr = r_r.tmr + 32'h0000_0001;
         if (r_r.tmr == 32'(HOLD_N - 1)) begin
            s_nxt.tmr_on = 1'b0;
            if (!r_r.ctrl[C_HOLD]) begin
               s_nxt.bias = 18'h00000; // R11
            end else if (r_r.ctrl[C_SRC+:2] == SRC_OP) begin
               s_nxt.opadj = 18'(r_r.opadj + s_nxt.bias); // R14
               s_nxt.bias  = 18'h00000;
            end else begin
               s_nxt.sbias = s_nxt.bias; // R15
            end
         end
      end
      if (stop && !r_r.ctrl[C_HOLD]) begin // R11
         s_nxt.bias = 18'h00000;
      end
      // Mode 1 with equal inputs zeroes the bias
      if (r_r.bcfg[15:0] == 16'h0000 && r_r.ctrl[C_BMODE] && eq2) begin
         s_nxt.bias  = 18'h00000; // R20
         s_nxt.sbias = 18'h00000; // R21
      end
      // Other reset conditions of the saved bias
      clr = !r_r.ctrl[C_UD2] || (s_nxt.ctrl[C_SRC+:2] != r_r.ctrl[C_SRC+:2]) || (s_nxt.maxf != r_r.maxf);
      if (clr) begin // R21
         s_nxt.sbias = 18'h00000;
         s_nxt.bias  = 18'h00000;
         s_nxt.opadj = 18'h00000;
      end
      // Freeze bias while an analog or pulse reference moves fast
      d = (ref_in > r_r.refp) ? ref_in - r_r.refp : r_r.refp - ref_in;
      if (tk) begin
         s_nxt.refp = ref_in;
         s_nxt.frz  = (r_r.ctrl[C_SRC+:2] != SRC_OP) &&
                      (bias_up || bias_dn) && (d > flim); // R22
      end
      // Base reference
      if (r_r.ctrl[C_UPDN]) begin
         base = r_r.udref;
      end else if (r_r.held_v) begin
         base = r_r.held; // R12
      end else begin
         base = ref_in; // R9
      end
      tot = $signed({4'h0, base}) +
            $signed({{2{r_r.opadj[17]}}, r_r.opadj}) +
            $signed({{2{r_r.bias[17]}}, r_r.bias});
      if (tot < 20'sh00000) begin
         v = 16'h0000;
      end else if (tot > $signed({4'h0, r_r.maxf})) begin
         v = r_r.maxf;
      end else begin
         v = tot[15:0];
      end
      // Lower limit
      s_nxt.lact = v < effl;
      if (v < effl) begin
         v = effl; // R1
      end
      // Jump bands, highest first; the ramp stage crosses them
      s_nxt.jact = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (!jdis && jf[i] != 16'h0000 &&
             v > jlo[i] && {1'b0, v} < jhi[i]) begin // R4 R7 R8
            v = jlo[i];
            s_nxt.jact = 1'b1;
         end
      end
      s_nxt.out = v;
   end

   //------------------------------------------------------------
   // State register
   //------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         r_r       <= '0;
         r_r.ctrl  <= CTRL_RST;
         r_r.lim   <= LIM_RST;
         r_r.maxf  <= MAXF_RST;
         r_r.j12   <= J12_RST;
         r_r.j3w   <= J3W_RST;
         r_r.bcfg  <= BIAS_RST;
         r_r.sbias <= SBIAS_RST;
      end else begin
         r_r <= s_nxt;
      end
   end

   // Outputs, straight from the state register; hreadyout and hresp tied off
   assign hrdata       = r_r.rdat;
   assign hreadyout    = 1'b1; // Zero wait states
   assign hresp        = 1'b0; // Always OKAY
   assign freq_ref_out = r_r.out;
   assign bias_out     = r_r.bias;
   assign jump_clamp   = r_r.jact;
   assign lower_clamp  = r_r.lact;

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   property p_lower;
      @(posedge clk) disable iff (rst)
      $stable(effl) && !r_r.jact |-> r_r.out >= effl;
   endproperty
   a_lower: assert property (p_lower) else $error("below lower limit"); // R1
   property p_master;
      @(posedge clk) disable iff (rst) ref_is_preset |-> effl == gl;
   endproperty
   a_master: assert property (p_master) else $error("master limit on preset"); // R2
   property p_larger;
      @(posedge clk) disable iff (rst)
      effl >= gl && (ref_is_preset || effl >= ml ||
      r_r.ctrl[C_SRC+:2] == SRC_OP || r_r.ctrl[C_SRC+:2] == 2'h3);
   endproperty
   a_larger: assert property (p_larger) else $error("lower limit not max"); // R3
   property p_band;
      @(posedge clk) disable iff (rst)
      $stable(r_r.j12) && $stable(r_r.j3w) && !jdis && jf[0] != 16'h0000
      |-> !(r_r.out > jlo[0] && {1'b0, r_r.out} < jhi[0]);
   endproperty
   a_band: assert property (p_band) else $error("output inside band"); // R4
   property p_jdis;
      @(posedge clk) disable iff (rst) jdis |=> !r_r.jact;
   endproperty
   a_jdis: assert property (p_jdis) else $error("jump with all zero"); // R6
   property p_stop;
      @(posedge clk) disable iff (rst)
      stop && !r_r.ctrl[C_HOLD] |=> r_r.bias == 18'h00000 &&
      !r_r.held_v && r_r.udref == 16'h0000;
   endproperty
   a_stop: assert property (p_stop) else $error("value kept on stop"); // R9
   property p_rel;
      @(posedge clk) disable iff (rst) !hold_in |=> !r_r.held_v;
   endproperty
   a_rel: assert property (p_rel) else $error("hold kept on release"); // R12
   property p_idle;
      @(posedge clk) disable iff (rst)
      (updn_up || updn_dn) && !run |=> r_r.udref == 16'h0000;
   endproperty
   a_idle: assert property (p_idle) else $error("up/down kept idle"); // R16
   property p_mode1;
      @(posedge clk) disable iff (rst)
      r_r.bcfg[15:0] == 16'h0000 && r_r.ctrl[C_BMODE] && bias_up == bias_dn
      |=> r_r.bias == 18'h00000 && r_r.sbias == 18'h00000;
   endproperty
   a_mode1: assert property (p_mode1) else $error("bias kept in mode 1"); // R20
   property p_fire;
      @(posedge clk) disable iff (rst)
      r_r.tmr_on && r_r.tmr == 32'(HOLD_N - 1) && !r_r.ctrl[C_HOLD] &&
      !bias_up && !bias_dn |=> r_r.bias == 18'h00000;
   endproperty
   a_fire: assert property (p_fire) else $error("bias kept after delay"); // R11
   c_jump:  cover property (@(posedge clk) disable iff (rst) r_r.jact);
   c_lower: cover property (@(posedge clk) disable iff (rst) r_r.lact);
   c_fire:  cover property (@(posedge clk) disable iff (rst)
                            r_r.tmr_on && r_r.tmr == 32'(HOLD_N - 1));
   c_frz:   cover property (@(posedge clk) disable iff (rst) r_r.frz);
endmodule
`default_nettype wire

//--- verif/frc_field.sv
// Far-side model: reference source (panel or analog input) and ramp rates
`timescale 1ns/1ns
`default_nettype none
module frc_field #(
   parameter logic [15:0] RATE_A = 16'h0003, // Active ramp step per tick
   parameter logic [15:0] RATE_F = 16'h0009  // Fourth ramp step per tick
) (
   input  wire logic        clk,
   input  wire logic [15:0] ref_set,
   input  wire logic        preset_set,
   output var  logic [15:0] ref_in,
   output var  logic        ref_is_preset,
   output var  logic [15:0] rate_act,
   output var  logic [15:0] rate_fourth
);
   //----------------------------------------
   // Source outputs
   //----------------------------------------
   // Source updates land one edge after the request
   always @(posedge clk) begin
      ref_in <= ref_set;
      ref_is_preset <= preset_set;
   end
   // Fixed ramp rates
   assign rate_act = RATE_A;
   assign rate_fourth = RATE_F;
endmodule
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the reference conditioner
`timescale 1ns/1ns
`default_nettype none
module tb;
   import frc_pkg::*;
   //----------------------------------------
   // Signals
   //----------------------------------------
   localparam int unsigned HN = 40; // Shortened 5 s delay
   logic        clk, rst, hwrite, hreadyout, hresp, run, power_ok, hold_in, updn_up, updn_dn;
   logic        bias_up, bias_dn, preset_set, ref_is_preset, jump_clamp, lower_clamp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [15:0] ref_set, ref_in, rate_act, rate_fourth, freq_ref_out;
   logic [17:0] bias_out;
   int          miscompares, samples_checked, cyc;
   logic [15:0] jr [5] = '{16'd4000, 16'd4100, 16'd2050, 16'd1000, 16'd4150}; // Inputs
   logic [15:0] je [5] = '{16'd3900, 16'd4100, 16'd1900, 16'd900, 16'd4150};  // Outputs
   logic        jc [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};                       // Clamp flags
   frc_top #(.HOLD_N(HN), .TICK_N(4)) u_frc_top (.clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ref_in(ref_in), .ref_is_preset(ref_is_preset),
      .run(run), .power_ok(power_ok), .updn_up(updn_up), .updn_dn(updn_dn), .hold_in(hold_in), .bias_up(bias_up),
      .bias_dn(bias_dn), .rate_act(rate_act), .rate_fourth(rate_fourth), .freq_ref_out(freq_ref_out),
      .bias_out(bias_out), .jump_clamp(jump_clamp), .lower_clamp(lower_clamp));
   frc_field u_frc_field (.clk(clk), .ref_set(ref_set), .preset_set(preset_set), .ref_in(ref_in),
      .ref_is_preset(ref_is_preset), .rate_act(rate_act), .rate_fourth(rate_fourth));
   //----------------------------------------
   // Helpers
   //----------------------------------------
   task automatic give_verdict;
      $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic wcy(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Address phase held until hready, then data phase until hready
   task automatic bus_xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      bus_xfer(a, 1'b1, d);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      bus_xfer(a, 1'b0, 32'h00000000);
      chk(rd, exp, what);
   endtask
   // One bias command, then a short settle
   task automatic press(input logic up);
      if (up) bias_up <= 1'b1; else bias_dn <= 1'b1;
      wcy(12);
      bias_up <= 1'b0;
      bias_dn <= 1'b0;
      wcy(4);
   endtask
   //----------------------------------------
   // Scenarios
   //----------------------------------------
   task automatic t_reset;
      rchk(A_CTRL, 32'h00000000, "ctrl reset");
      rchk(A_LIM, 32'h00000000, "limits reset");
      rchk(A_MAXF, 32'h00001770, "max freq reset");
      rchk(A_J12, 32'h00000000, "jumps reset");
      rchk(A_J3W, 32'h00640000, "band width reset");
      rchk(A_BIAS, 32'h000A0000, "bias reset");
      rchk(A_SBIAS, 32'h00000000, "saved bias reset");
      rchk(8'h40, 32'h00000000, "unmapped read");
   endtask
   task automatic t_limits;
      run <= 1'b1;
      bus_wr(A_LIM, 32'h00C80064);
      rchk(A_LIM, 32'h00C80064, "limits readback");
      ref_set <= 16'd300;
      wcy(4);
      chk({16'h0000, freq_ref_out}, 32'd600, "general limit");
      chk({31'h0, lower_clamp}, 32'h1, "lower clamp flag");
      bus_wr(A_CTRL, 32'h00000010);
      wcy(4);
      chk({16'h0000, freq_ref_out}, 32'd1200, "master limit");
      preset_set <= 1'b1;
      wcy(4);
      chk({16'h0000, freq_ref_out}, 32'd600, "preset skips master");
      preset_set <= 1'b0;
      bus_wr(A_LIM, 32'h006400C8);
      wcy(4);
      chk({16'h0000, freq_ref_out}, 32'd1200, "larger limit wins");
      ref_set <= 16'd2000;
      wcy(4);
      chk({15'h0, lower_clamp, freq_ref_out}, 32'd2000, "above limit");
      bus_wr(A_LIM, 32'h00000000);
   endtask
   task automatic t_jumps;
      bus_wr(A_CTRL, 32'h00000000);
      ref_set <= 16'd4000;
      wcy(4);
      chk({15'h0, jump_clamp, freq_ref_out}, 32'd4000, "jumps off");
      bus_wr(A_J12, 32'h07D00FA0);
      bus_wr(A_J3W, 32'h00C803E8);
      for (int i = 0; i < 5; i++) begin
         ref_set <= jr[i];
         wcy(4);
         chk({15'h0, jump_clamp, freq_ref_out}, {15'h0, jc[i], je[i]}, "jump band");
      end
      bus_wr(A_J12, 32'h00000000);
      bus_wr(A_J3W, 32'h00640000);
   endtask
   task automatic t_bias_step;
      run <= 1'b0;
      bus_wr(A_BIAS, 32'h000A0032);
      bus_wr(A_CTRL, 32'h00000008);
      run <= 1'b1;
      wcy(4);
      press(1'b1);
      chk({14'h0, bias_out}, 32'd50, "one step up");
      press(1'b1);
      chk({14'h0, bias_out}, 32'd100, "two steps up");
      press(1'b0);
      chk({14'h0, bias_out}, 32'd50, "one step down");
      wcy(HN + 10);
      chk({14'h0, bias_out}, 32'd0, "bias dropped after delay");
      press(1'b1);
      power_ok <= 1'b0;
      wcy(3);
      chk({14'h0, bias_out}, 32'd0, "bias dropped at power loss");
      power_ok <= 1'b1;
   endtask
   task automatic t_bias_ramp;
      run <= 1'b0;
      bus_wr(A_BIAS, 32'h000A0000);
      bus_wr(A_CTRL, 32'h0000000C);
      run <= 1'b1;
      bias_up <= 1'b1;
      wcy(40);
      chk({31'h0, bias_out > 0 && bias_out <= 40}, 32'h1, "ramp at active rate");
      bias_up <= 1'b0;
      wcy(3);
      chk({14'h0, bias_out}, 32'd0, "both off resets");
      bias_up <= 1'b1;
      bias_dn <= 1'b1;
      wcy(8);
      chk({14'h0, bias_out}, 32'd0, "both on resets");
      bus_wr(A_CTRL, 32'h0000000E);
      bias_dn <= 1'b0;
      wcy(40);
      chk({31'h0, bias_out > 40 && bias_out[17] == 1'b0}, 32'h1, "ramp at fourth rate");
      bias_up <= 1'b0;
   endtask
   task automatic t_hold_bias;
      run <= 1'b0;
      bus_wr(A_BIAS, 32'h000A0032);
      bus_wr(A_CTRL, 32'h00000019);
      run <= 1'b1;
      wcy(4);
      press(1'b1);
      wcy(HN + 10);
      rchk(A_SBIAS, 32'd50, "bias saved after delay");
      bus_wr(A_CTRL, 32'h00000009);
      rchk(A_SBIAS, 32'd0, "source change clears saved bias");
      run <= 1'b0;
      ref_set <= 16'd1000;
      wcy(2);
      run <= 1'b1;
      wcy(4);
      press(1'b1);
      wcy(HN + 10);
      chk({14'h0, bias_out}, 32'd0, "panel bias zeroed");
      chk({16'h0000, freq_ref_out}, 32'd1050, "panel bias folded in");
   endtask
   task automatic t_hold_ref;
      run <= 1'b0;
      bus_wr(A_CTRL, 32'h00000001);
      run <= 1'b1;
      ref_set <= 16'd1500;
      wcy(4);
      hold_in <= 1'b1;
      wcy(6);
      run <= 1'b0;
      wcy(4);
      rchk(A_HOLD, 32'd1500, "hold value kept");
      hold_in <= 1'b0;
      wcy(3);
      rchk(A_HOLD, 32'h00000000, "hold release clears");
   endtask
   task automatic t_updn;
      bus_wr(A_CTRL, 32'h00000041);
      run <= 1'b1;
      updn_up <= 1'b1;
      wcy(8);
      {run, updn_up} <= 2'b00;
      wcy(4);
      rchk(A_HOLD, 32'h00060000, "up/down kept");
      updn_dn <= 1'b1;
      wcy(2);
      rchk(A_HOLD, 32'h00000000, "idle down clears");
   endtask
   //----------------------------------------
   // Clock, timeout and main sequence
   //----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      {rst, hwrite, run, hold_in, bias_up, bias_dn, preset_set, updn_up, updn_dn} = 9'b100000000;
      power_ok = 1'b1;
      {haddr, hwdata, htrans, ref_set} = '0;
      {miscompares, samples_checked, cyc} = '0;
      wcy(2);
      rst <= 1'b0;
      wcy(1);
      chk({16'h0000, freq_ref_out}, 32'd0, "output after reset");
      t_reset();
      t_limits();
      t_jumps();
      t_bias_step();
      t_bias_ramp();
      t_hold_bias();
      t_hold_ref();
      t_updn();
      give_verdict();
   end
endmodule
`default_nettype wire
